// ### core/gpio_pkg.sv
package gpio_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 8;
    localparam int NIBBLE_W   = 4;
    localparam int NUM_BANKS  = 2;
    localparam int PORTS_BANK = 3;
    localparam int NUM_PORTS  = NUM_BANKS * PORTS_BANK;

    // ------------------------------------------------------------
    // byte offsets from the i/o base
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_BANK1_FIRST  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_BANK1_SECOND = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_BANK1_SPLIT  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_BANK1_CTRL   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_BANK2_FIRST  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_BANK2_SECOND = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_BANK2_SPLIT  = 4'ha;
    localparam logic [ADDR_W-1:0] OFS_BANK2_CTRL   = 4'hb;

    // port index order: bank1 first, second, split, bank2 first, second, split
    localparam logic [ADDR_W-1:0] PORT_OFS [NUM_PORTS] = '{
        OFS_BANK1_FIRST, OFS_BANK1_SECOND, OFS_BANK1_SPLIT,
        OFS_BANK2_FIRST, OFS_BANK2_SECOND, OFS_BANK2_SPLIT
    };
    localparam logic [ADDR_W-1:0] CTRL_OFS [NUM_BANKS] = '{
        OFS_BANK1_CTRL, OFS_BANK2_CTRL
    };

    // position of each port inside its bank
    localparam int KIND_FIRST  = 0;
    localparam int KIND_SECOND = 1;
    localparam int KIND_SPLIT  = 2;

    // ------------------------------------------------------------
    // control word fields (1 = input)
    // ------------------------------------------------------------
    localparam int SPLIT_LOW_HALF_DIR_BIT     = 0;
    localparam int SECOND_PORT_DIR_BIT        = 1;
    localparam int SPLIT_HIGH_HALF_DIR_BIT    = 3;
    localparam int FIRST_PORT_DIR_BIT         = 4;
    localparam int CONTROL_WORD_FIXED_ONE_BIT = 7;

    localparam logic DIR_INPUT = 1'b1;

    // ------------------------------------------------------------
    // reset and read values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] HOLD_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] READ_NONE    = 8'h00;
    // undriven lines idle high through the pull-ups; syncs start there
    localparam logic [DATA_W-1:0] PIN_RESET    = 8'hff;

    // interrupt source: bank1 first port, bit 0
    localparam int IRQ_PORT = 0;
    localparam int IRQ_BIT  = 0;

endpackage

// ### core/pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_raw,
    input  wire logic [WIDTH-1:0] reset_value,
    output logic      [WIDTH-1:0] pin_stable
);

    // ------------------------------------------------------------
    // three stages; a bit changes once stages two and three agree
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;
    logic [WIDTH-1:0] agree;

    assign agree      = ~(s2_q ^ s3_q);
    assign stable_d   = (agree & s2_q) | (~agree & stable_q);
    assign pin_stable = stable_q;

    always_ff @(posedge clk) begin
        // start at the idle level so no false edge follows reset
        if (sys_rst) begin
            meta_q   <= reset_value;
            s2_q     <= reset_value;
            s3_q     <= reset_value;
            stable_q <= reset_value;
        end else begin
            meta_q   <= pin_raw;
            s2_q     <= meta_q;
            s3_q     <= s2_q;
            stable_q <= stable_d;
        end
    end

endmodule

// ### core/dual_bank_parallel_io_ports.sv
module dual_bank_parallel_io_ports
    import gpio_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // byte-wide i/o access
    input  wire logic [gpio_pkg::ADDR_W-1:0]   io_addr,
    input  wire logic                          io_wr,
    input  wire logic                          io_rd,
    input  wire logic [gpio_pkg::DATA_W-1:0]   io_wdata,
    output logic      [gpio_pkg::DATA_W-1:0]   io_rdata,
    output logic                               io_rvalid,
    // bank 1 pins
    input  wire logic [gpio_pkg::DATA_W-1:0]   bank1_first_byte_port_in,
    output logic      [gpio_pkg::DATA_W-1:0]   bank1_first_byte_port_out,
    output logic      [gpio_pkg::DATA_W-1:0]   bank1_first_byte_port_oe,
    input  wire logic [gpio_pkg::DATA_W-1:0]   bank1_second_byte_port_in,
    output logic      [gpio_pkg::DATA_W-1:0]   bank1_second_byte_port_out,
    output logic      [gpio_pkg::DATA_W-1:0]   bank1_second_byte_port_oe,
    input  wire logic [gpio_pkg::DATA_W-1:0]   bank1_split_nibble_port_in,
    output logic      [gpio_pkg::DATA_W-1:0]   bank1_split_nibble_port_out,
    output logic      [gpio_pkg::DATA_W-1:0]   bank1_split_nibble_port_oe,
    // bank 2 pins
    input  wire logic [gpio_pkg::DATA_W-1:0]   bank2_first_byte_port_in,
    output logic      [gpio_pkg::DATA_W-1:0]   bank2_first_byte_port_out,
    output logic      [gpio_pkg::DATA_W-1:0]   bank2_first_byte_port_oe,
    input  wire logic [gpio_pkg::DATA_W-1:0]   bank2_second_byte_port_in,
    output logic      [gpio_pkg::DATA_W-1:0]   bank2_second_byte_port_out,
    output logic      [gpio_pkg::DATA_W-1:0]   bank2_second_byte_port_oe,
    input  wire logic [gpio_pkg::DATA_W-1:0]   bank2_split_nibble_port_in,
    output logic      [gpio_pkg::DATA_W-1:0]   bank2_split_nibble_port_out,
    output logic      [gpio_pkg::DATA_W-1:0]   bank2_split_nibble_port_oe,
    // interrupt source
    output logic                               irq_level,
    output logic                               irq_rise
);

    import gpio_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // per-bit input mask of a port from its bank's control word
    function automatic logic [DATA_W-1:0] input_mask(
        input logic [DATA_W-1:0] ctrl,
        input int                kind
    );
        logic [DATA_W-1:0] m;
        m = '0;
        if (kind == KIND_FIRST) begin
            m = {DATA_W{ctrl[FIRST_PORT_DIR_BIT]}};
        end else if (kind == KIND_SECOND) begin
            m = {DATA_W{ctrl[SECOND_PORT_DIR_BIT]}};
        end else begin
            m = {{NIBBLE_W{ctrl[SPLIT_HIGH_HALF_DIR_BIT]}},
                 {NIBBLE_W{ctrl[SPLIT_LOW_HALF_DIR_BIT]}}};
        end
        return m;
    endfunction

    // input bits show the pin, output bits show the holding register
    function automatic logic [DATA_W-1:0] merge_read(
        input logic [DATA_W-1:0] in_mask,
        input logic [DATA_W-1:0] pin,
        input logic [DATA_W-1:0] hold
    );
        return (in_mask & pin) | (~in_mask & hold);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] pin_raw    [NUM_PORTS];
    logic [DATA_W-1:0] pin_stable [NUM_PORTS];

    assign pin_raw[0] = bank1_first_byte_port_in;
    assign pin_raw[1] = bank1_second_byte_port_in;
    assign pin_raw[2] = bank1_split_nibble_port_in;
    assign pin_raw[3] = bank2_first_byte_port_in;
    assign pin_raw[4] = bank2_second_byte_port_in;
    assign pin_raw[5] = bank2_split_nibble_port_in;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_sync
        pin_sync #(
            .WIDTH       (DATA_W)
        ) u_sync (
            .clk         (clk),
            .sys_rst     (sys_rst),
            .pin_raw     (pin_raw[p]),
            .reset_value (PIN_RESET),
            .pin_stable  (pin_stable[p])
        );
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] port_hit;
    logic [NUM_BANKS-1:0] ctrl_hit;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_dec
        assign port_hit[p] = (io_addr == PORT_OFS[p]);
    end
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_ctrl_dec
        assign ctrl_hit[b] = (io_addr == CTRL_OFS[b]);
    end

    // ------------------------------------------------------------
    // control words, one per bank
    // ------------------------------------------------------------
    // only direction bits are stored; the other bits are always held at zero
    logic [DATA_W-1:0] dir_keep;
    logic [DATA_W-1:0] ctrl_q [NUM_BANKS];

    assign dir_keep = (DATA_W'(1) << SPLIT_LOW_HALF_DIR_BIT)
                    | (DATA_W'(1) << SECOND_PORT_DIR_BIT)
                    | (DATA_W'(1) << SPLIT_HIGH_HALF_DIR_BIT)
                    | (DATA_W'(1) << FIRST_PORT_DIR_BIT);

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_ctrl
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                ctrl_q[b] <= {DATA_W{DIR_INPUT}} & dir_keep;
            end else if (io_wr && ctrl_hit[b]) begin
                ctrl_q[b] <= io_wdata & dir_keep;
            end
        end
    end

    // ------------------------------------------------------------
    // holding registers and drive enables
    // ------------------------------------------------------------
    // holding regs accept writes in either direction so the host can
    // preset a value before turning the port around
    logic [DATA_W-1:0] hold_q  [NUM_PORTS];
    logic [DATA_W-1:0] oe_q    [NUM_PORTS];
    logic [DATA_W-1:0] in_mask [NUM_PORTS];
    logic [DATA_W-1:0] rd_mux  [NUM_PORTS];

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        assign in_mask[p] = input_mask(ctrl_q[p / PORTS_BANK], p % PORTS_BANK);
        assign rd_mux[p]  = merge_read(in_mask[p], pin_stable[p], hold_q[p]);

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                hold_q[p] <= HOLD_RESET;
                oe_q[p]   <= '0;
            end else begin
                if (io_wr && port_hit[p]) begin
                    hold_q[p] <= io_wdata;
                end
                oe_q[p] <= ~in_mask[p];
            end
        end
    end

    assign bank1_first_byte_port_out   = hold_q[0];
    assign bank1_second_byte_port_out  = hold_q[1];
    assign bank1_split_nibble_port_out = hold_q[2];
    assign bank2_first_byte_port_out   = hold_q[3];
    assign bank2_second_byte_port_out  = hold_q[4];
    assign bank2_split_nibble_port_out = hold_q[5];
    assign bank1_first_byte_port_oe    = oe_q[0];
    assign bank1_second_byte_port_oe   = oe_q[1];
    assign bank1_split_nibble_port_oe  = oe_q[2];
    assign bank2_first_byte_port_oe    = oe_q[3];
    assign bank2_second_byte_port_oe   = oe_q[4];
    assign bank2_split_nibble_port_oe  = oe_q[5];

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // control words are write only; they and unmapped offsets read zero
    logic [DATA_W-1:0] rd_sel;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_q;

    always_comb begin
        rd_sel = READ_NONE;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_hit[p]) begin
                rd_sel = rd_mux[p];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q  <= READ_NONE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= io_rd;
            if (io_rd) begin
                rdata_q <= rd_sel;
            end
        end
    end

    assign io_rdata  = rdata_q;
    assign io_rvalid = rvalid_q;

    // ------------------------------------------------------------
    // interrupt source
    // ------------------------------------------------------------
    // taken from the filtered pin, whatever the port direction
    logic irq_level_q;
    logic irq_rise_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_level_q <= PIN_RESET[IRQ_BIT];
            irq_rise_q  <= 1'b0;
        end else begin
            irq_level_q <= pin_stable[IRQ_PORT][IRQ_BIT];
            irq_rise_q  <= pin_stable[IRQ_PORT][IRQ_BIT] & ~irq_level_q;
        end
    end

    assign irq_level = irq_level_q;
    assign irq_rise  = irq_rise_q;

endmodule

// ### testbench/io_ports_monitor.sv
module io_ports_monitor
    import gpio_pkg::*;
(
    input wire logic                          clk,
    input wire logic                          sys_rst,
    input wire logic [gpio_pkg::ADDR_W-1:0]   io_addr,
    input wire logic                          io_wr,
    input wire logic                          io_rd,
    input wire logic [gpio_pkg::DATA_W-1:0]   io_wdata,
    input wire logic [gpio_pkg::DATA_W-1:0]   io_rdata,
    input wire logic                          io_rvalid,
    input wire logic [gpio_pkg::DATA_W-1:0]   bank1_first_byte_port_out,
    input wire logic [gpio_pkg::DATA_W-1:0]   bank1_first_byte_port_oe,
    input wire logic [gpio_pkg::DATA_W-1:0]   bank2_split_nibble_port_oe,
    input wire logic                          irq_level,
    input wire logic                          irq_rise
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_rd_answer;
        io_rd |=> io_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered one cycle later");

    property p_rd_quiet;
        !io_rd |=> !io_rvalid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read valid without a read");

    property p_hold_write;
        io_wr && io_addr == OFS_BANK1_FIRST |=> bank1_first_byte_port_out == $past(io_wdata);
    endproperty
    a_hold_write: assert property (p_hold_write)
        else $error("holding register missed a write");

    property p_hold_keep;
        !(io_wr && io_addr == OFS_BANK1_FIRST) |=> $stable(bank1_first_byte_port_out);
    endproperty
    a_hold_keep: assert property (p_hold_keep)
        else $error("holding register changed without a write");

    property p_first_dir;
        io_wr && io_addr == OFS_BANK1_CTRL |->
            ##2 bank1_first_byte_port_oe == {8{~$past(io_wdata[4], 2)}};
    endproperty
    a_first_dir: assert property (p_first_dir)
        else $error("first port direction wrong");

    property p_split_dir;
        io_wr && io_addr == OFS_BANK2_CTRL |-> ##2 bank2_split_nibble_port_oe ==
            {{4{~$past(io_wdata[3], 2)}}, {4{~$past(io_wdata[0], 2)}}};
    endproperty
    a_split_dir: assert property (p_split_dir)
        else $error("split port nibble directions wrong");

    property p_readback;
        (io_rd && io_addr == OFS_BANK1_FIRST && &bank1_first_byte_port_oe)
            ##1 &bank1_first_byte_port_oe |-> io_rdata == $past(bank1_first_byte_port_out);
    endproperty
    a_readback: assert property (p_readback)
        else $error("output port read not the driven value");

    property p_reset_inputs;
        disable iff (1'b0)
        sys_rst |=> bank1_first_byte_port_oe == 8'h00 && bank2_split_nibble_port_oe == 8'h00;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("port driven after reset");

    property p_irq;
        irq_rise == (irq_level && !$past(irq_level));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pulse not matching a level rise");
endmodule

bind dual_bank_parallel_io_ports io_ports_monitor u_io_ports_monitor (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .bank1_first_byte_port_out(bank1_first_byte_port_out),
    .bank1_first_byte_port_oe(bank1_first_byte_port_oe),
    .bank2_split_nibble_port_oe(bank2_split_nibble_port_oe),
    .irq_level(irq_level), .irq_rise(irq_rise)
);

// ### testbench/field_wiring.sv
module field_wiring (
    input  wire logic [47:0] port_out,
    input  wire logic [47:0] port_oe,
    input  wire logic [47:0] ext_val,
    input  wire logic [47:0] ext_en,
    output logic      [47:0] pin_level
);
    timeunit 1ns;
    timeprecision 100ps;
    // undriven lines sit high through the pull-ups, never unknown
    assign pin_level = (port_oe & port_out) | (~port_oe & ext_en & ext_val) | (~port_oe & ~ext_en);
endmodule

// ### testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import gpio_pkg::*;

    typedef struct packed {
        logic [3:0] ca;
        logic [7:0] cw;
        logic [3:0] pa;
        logic       wr;
        logic [7:0] wv, ext, rd, oe;
    } row_s;

    logic clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, io_rvalid, irq_level, irq_rise;
    logic [3:0]  io_addr = '0;
    logic [7:0]  io_wdata = '0, io_rdata, q;
    logic [7:0]  bank1_first_byte_port_in, bank1_first_byte_port_out, bank1_first_byte_port_oe;
    logic [7:0]  bank1_second_byte_port_in, bank1_second_byte_port_out, bank1_second_byte_port_oe;
    logic [7:0]  bank1_split_nibble_port_in, bank1_split_nibble_port_out, bank1_split_nibble_port_oe;
    logic [7:0]  bank2_first_byte_port_in, bank2_first_byte_port_out, bank2_first_byte_port_oe;
    logic [7:0]  bank2_second_byte_port_in, bank2_second_byte_port_out, bank2_second_byte_port_oe;
    logic [7:0]  bank2_split_nibble_port_in, bank2_split_nibble_port_out, bank2_split_nibble_port_oe;
    logic [47:0] ext_val = '0, ext_en = '1, pin_level, out_all, oe_all;
    int          err_total = 0, checked = 0, idx, n;

    // control writes: preset first, bits 2/5/6 toggled to show they are ignored
    row_s rows [10] = '{
        '{4'h3, 8'hff, 4'h0, 1'b1, 8'h3c, 8'ha5, 8'ha5, 8'h00},
        '{4'h3, 8'he4, 4'h0, 1'b0, 8'h00, 8'ha5, 8'h3c, 8'hff},
        '{4'h3, 8'hef, 4'h1, 1'b1, 8'h11, 8'h77, 8'h77, 8'h00},
        '{4'h3, 8'h89, 4'h1, 1'b1, 8'h22, 8'h77, 8'h22, 8'hff},
        '{4'h3, 8'h81, 4'h2, 1'b1, 8'h3c, 8'ha5, 8'h35, 8'hf0},
        '{4'h3, 8'h88, 4'h2, 1'b1, 8'hc3, 8'h5a, 8'h53, 8'h0f},
        '{4'hb, 8'h80, 4'h8, 1'b1, 8'h96, 8'h00, 8'h96, 8'hff},
        '{4'hb, 8'hff, 4'h9, 1'b1, 8'h01, 8'h6b, 8'h6b, 8'h00},
        '{4'hb, 8'h9d, 4'h9, 1'b1, 8'h42, 8'h6b, 8'h42, 8'hff},
        '{4'hb, 8'h88, 4'ha, 1'b1, 8'hc3, 8'h5a, 8'h53, 8'h0f}
    };

    always #2.5 clk = ~clk;

    assign out_all = {bank2_split_nibble_port_out, bank2_second_byte_port_out,
        bank2_first_byte_port_out, bank1_split_nibble_port_out, bank1_second_byte_port_out,
        bank1_first_byte_port_out};
    assign oe_all = {bank2_split_nibble_port_oe, bank2_second_byte_port_oe,
        bank2_first_byte_port_oe, bank1_split_nibble_port_oe, bank1_second_byte_port_oe,
        bank1_first_byte_port_oe};
    assign {bank2_split_nibble_port_in, bank2_second_byte_port_in, bank2_first_byte_port_in,
        bank1_split_nibble_port_in, bank1_second_byte_port_in, bank1_first_byte_port_in} = pin_level;

    field_wiring u_field_wiring (.port_out(out_all), .port_oe(oe_all), .ext_val, .ext_en,
        .pin_level);

    dual_bank_parallel_io_ports u_dual_bank_parallel_io_ports (.clk, .sys_rst, .io_addr,
        .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rvalid, .bank1_first_byte_port_in,
        .bank1_first_byte_port_out, .bank1_first_byte_port_oe, .bank1_second_byte_port_in,
        .bank1_second_byte_port_out, .bank1_second_byte_port_oe, .bank1_split_nibble_port_in,
        .bank1_split_nibble_port_out, .bank1_split_nibble_port_oe, .bank2_first_byte_port_in,
        .bank2_first_byte_port_out, .bank2_first_byte_port_oe, .bank2_second_byte_port_in,
        .bank2_second_byte_port_out, .bank2_second_byte_port_oe, .bank2_split_nibble_port_in,
        .bank2_split_nibble_port_out, .bank2_split_nibble_port_oe, .irq_level, .irq_rise);

    // ------------------------------------------------------------
    // host access, entered and left just after a rising edge
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic w(input logic [3:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        #1;
        io_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic r(input logic [3:0] a, output logic [7:0] d);
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        #1;
        io_rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, io_rvalid});
        d = io_rdata;
        @(posedge clk);
        #1;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            idx = rows[i].pa[3] * 3 + rows[i].pa[1:0];
            ext_val[idx*8+:8] = rows[i].ext;
            w(rows[i].ca, rows[i].cw);
            if (rows[i].wr) w(rows[i].pa, rows[i].wv);
            repeat (6) @(posedge clk);
            #1;
            r(rows[i].pa, q);
            chk("rdata", rows[i].rd, q);
            chk("oe", rows[i].oe, oe_all[idx*8+:8]);
            if (rows[i].wr) chk("out", rows[i].wv, out_all[idx*8+:8]);
            $display("row %0d done", i);
        end
        r(4'h5, q);
        chk("unmapped", 8'h00, q);
        $display("unmapped read done");
        // mid-run reset with lines left floating
        ext_en = '0;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("oe after reset", 8'h00, {7'h00, |oe_all});
        repeat (6) @(posedge clk);
        #1;
        r(4'h0, q);
        chk("pulled up", 8'hff, q);
        $display("reset test done");
        ext_en = '1;
        ext_val = '0;
        repeat (6) @(posedge clk);
        #1;
        ext_val[0] = 1'b1;
        for (n = 0; n < 12 && irq_rise !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("irq_rise", 8'h01, {7'h00, irq_rise});
        chk("irq_level", 8'h01, {7'h00, irq_level});
        $display("interrupt test done");
        complete_run();
    end
endmodule
